// ### rtl/nic_ctrl.sv
// Purpose: Enable, pending and active state of 32 interrupt lines,
//          priority arbitration and the word register port.
// Assumes: Request lines are synchronous to CLOCK; the core reports
//          service entry and return as one-cycle pulses.
// Notes:   Line type (level or pulse) is chosen per line by IRQ_LEVEL.
//
// Operation
// RQ1: Enable-set writes of 1 enable a line; reads show enables.
// RQ2: A pending and enabled line is offered to the core by priority; the code offers it only while it is not active.
// RQ3: Disabled lines still become pending but are never offered.
// RQ4: Enable-clear writes of 1 disable a line; reads show enables.
// RQ5: Pending-set writes of 1 make a line pending; reads show pending.
// RQ6: Setting an already pending line changes nothing; disabled lines pend.
// RQ7: Pending-clear writes of 1 remove pending; reads show pending.
// RQ8: Pending-clear never touches the active state.
// RQ9: Only bits 7:6 of each priority byte are stored; rest read zero.
// RQ10: Priority 0 to 3; lower value wins arbitration.
// RQ11: Priority words are reached by full-word accesses only.
// RQ12: Interrupt M lives in priority word M div 4, lane M mod 4.
// RQ13: Pulse requests are sampled each clock edge and latched pending.
// RQ14: A pulse request stays high for at least one clock cycle.
// RQ15: A level request stays high until its service is done.
// RQ16: Entering service clears the pending state automatically.
// RQ17: A level request still high at return pends again.
// RQ18: A sensed request on a line that is not active makes it pending.
// RQ19: A pulse during service gives active and pending; pending survives.
// RQ20: Bit n of the four vector registers belongs to interrupt n.

`timescale 1ns/1ns
`default_nettype none

module nic_ctrl
   import nic_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [NIC_NUM_IRQ-1:0] IRQ_REQ,
   input wire logic [NIC_NUM_IRQ-1:0] IRQ_LEVEL,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic REG_WORD,
   input wire logic [NIC_ADDR_W-1:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   output logic OFFER_VALID,
   output logic [NIC_NUM_W-1:0] OFFER_NUM,
   output logic [NIC_PRIO_W-1:0] OFFER_PRIO,
   input wire logic CORE_ENTER,
   input wire logic [NIC_NUM_W-1:0] CORE_ENTER_NUM,
   input wire logic CORE_RETURN,
   input wire logic [NIC_NUM_W-1:0] CORE_RETURN_NUM,
   output logic [NIC_NUM_IRQ-1:0] ACTIVE_STATE
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------

   // Maps a byte offset to the register it selects.
   function automatic nic_sel_t decode(input logic [NIC_ADDR_W-1:0] a);
      nic_sel_t s;
      s = NIC_SEL_NONE;
      if (a == NIC_OFF_ENA_SET) begin
         s = NIC_SEL_ENA_SET;
      end else if (a == NIC_OFF_ENA_CLR) begin
         s = NIC_SEL_ENA_CLR;
      end else if (a == NIC_OFF_PEND_SET) begin
         s = NIC_SEL_PEND_SET;
      end else if (a == NIC_OFF_PEND_CLR) begin
         s = NIC_SEL_PEND_CLR;
      end else if (a >= NIC_OFF_PRIO_FIRST && a <= NIC_OFF_PRIO_LAST &&
                   a[1:0] == 2'b00) begin
         s = NIC_SEL_PRIO;
      end
      return s;
   endfunction : decode

   // One-hot mask of a line number.
   function automatic logic [NIC_NUM_IRQ-1:0] onehot(
      input logic [NIC_NUM_W-1:0] n
   );
      logic [NIC_NUM_IRQ-1:0] m;
      m = '0;
      m[n] = 1'b1;
      return m;
   endfunction : onehot

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [NIC_NUM_IRQ-1:0] enable;
   logic [NIC_NUM_IRQ-1:0] pending;
   logic [NIC_NUM_IRQ-1:0] active;
   logic [NIC_NUM_IRQ-1:0] req_prev;
   logic [NIC_NUM_IRQ-1:0] next_enable;
   logic [NIC_NUM_IRQ-1:0] next_pending;
   logic [NIC_NUM_IRQ-1:0] next_active;
   logic [2*NIC_NUM_IRQ-1:0] prio_flat;
   logic [31:0] prio_rdata;
   logic [31:0] vec_rdata;
   logic rd_prio;
   logic rd_prio_q;

   // ---------------------------------------------------------------
   // Register port decode
   // ---------------------------------------------------------------
   nic_sel_t sel;
   logic wr_ok;
   logic rd_ok;

   // Narrow accesses are ignored for writes and read back as zero.
   assign sel = decode(REG_ADDR);
   assign wr_ok = REG_WR & REG_WORD; // see RQ11
   assign rd_ok = REG_RD & REG_WORD; // see RQ11

   logic [NIC_NUM_IRQ-1:0] sw_ena_set;
   logic [NIC_NUM_IRQ-1:0] sw_ena_clr;
   logic [NIC_NUM_IRQ-1:0] sw_pend_set;
   logic [NIC_NUM_IRQ-1:0] sw_pend_clr;

   // Bit n of the data word acts on line n.
   assign sw_ena_set = (wr_ok && sel == NIC_SEL_ENA_SET) ?
                       REG_WDATA : '0; // see RQ1, see RQ20
   assign sw_ena_clr = (wr_ok && sel == NIC_SEL_ENA_CLR) ?
                       REG_WDATA : '0; // see RQ4, see RQ20
   assign sw_pend_set = (wr_ok && sel == NIC_SEL_PEND_SET) ?
                        REG_WDATA : '0; // see RQ5, see RQ20
   assign sw_pend_clr = (wr_ok && sel == NIC_SEL_PEND_CLR) ?
                        REG_WDATA : '0; // see RQ7, see RQ20

   // ---------------------------------------------------------------
   // Enable vector
   // ---------------------------------------------------------------
   always_comb begin
      next_enable = (enable | sw_ena_set) & ~sw_ena_clr; // see RQ1, see RQ4
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         enable <= NIC_RST_ENABLE;
      end else begin
         enable <= next_enable;
      end
   end

   // ---------------------------------------------------------------
   // Request sensing
   // ---------------------------------------------------------------
   logic [NIC_NUM_IRQ-1:0] enter_mask;
   logic [NIC_NUM_IRQ-1:0] return_mask;
   logic [NIC_NUM_IRQ-1:0] level_set;
   logic [NIC_NUM_IRQ-1:0] pulse_set;
   logic [NIC_NUM_IRQ-1:0] hw_set;

   // Entry is honoured only for a line that is pending and enabled, active or not.
   assign enter_mask = CORE_ENTER ?
      (onehot(CORE_ENTER_NUM) & pending & enable) : '0; // see RQ3
   assign return_mask = CORE_RETURN ?
      (onehot(CORE_RETURN_NUM) & active) : '0;

   // A level line pends while high and neither active nor being entered,
   // and again at return when it is still high.
   assign level_set = IRQ_LEVEL & IRQ_REQ &
      (~active & ~enter_mask | return_mask); // see RQ18, see RQ17, see RQ16

   // A pulse line pends on each sampled rising edge, active or not.
   assign pulse_set = ~IRQ_LEVEL & IRQ_REQ & ~req_prev; // see RQ13, see RQ19

   assign hw_set = level_set | pulse_set; // see RQ3

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         req_prev <= '0;
      end else begin
         req_prev <= IRQ_REQ; // see RQ13, see RQ14
      end
   end

   // ---------------------------------------------------------------
   // Pending vector
   // ---------------------------------------------------------------
   // Setting wins over clearing in the same cycle, so a request that
   // arrives with an entry or a software clear is not lost.
   always_comb begin
      next_pending = (pending & ~sw_pend_clr & ~enter_mask) |
                     sw_pend_set | hw_set; // see RQ16, see RQ6, see RQ7
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         pending <= NIC_RST_PENDING;
      end else begin
         pending <= next_pending; // see RQ5, see RQ19
      end
   end

   // ---------------------------------------------------------------
   // Active vector
   // ---------------------------------------------------------------
   // Pending-clear writes do not appear here at all.
   always_comb begin
      next_active = (active | enter_mask) & ~return_mask; // see RQ8
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         active <= NIC_RST_ACTIVE;
      end else begin
         active <= next_active;
      end
   end

   assign ACTIVE_STATE = active;

   // ---------------------------------------------------------------
   // Priority storage
   // ---------------------------------------------------------------
   logic prio_wr;
   logic [NIC_PRIO_IDX_W-1:0] prio_idx;

   // Word index is the register number, lane is the field.
   assign prio_idx = REG_ADDR[NIC_PRIO_IDX_W+1:2]; // see RQ12
   assign prio_wr = wr_ok && sel == NIC_SEL_PRIO; // see RQ11
   assign rd_prio = rd_ok && sel == NIC_SEL_PRIO;

   nic_prio_mem u_prio (
      .clk(CLOCK),
      .rst(RESET),
      .wr_en(prio_wr),
      .rd_en(rd_prio),
      .idx(prio_idx),
      .wdata(REG_WDATA),
      .rdata(prio_rdata),
      .prio_flat(prio_flat)
   ); // see RQ9, see RQ12

   // ---------------------------------------------------------------
   // Arbitration
   // ---------------------------------------------------------------
   logic [NIC_NUM_IRQ-1:0] candidate;
   logic best_found;
   logic [NIC_NUM_W-1:0] best_num;
   logic [NIC_PRIO_W-1:0] best_prio;

   assign candidate = pending & enable & ~active; // see RQ2, see RQ3

   // Lowest value wins; among equals the lowest line number wins.
   always_comb begin
      best_found = 1'b0;
      best_num = '0;
      best_prio = '1;
      for (int m = 0; m < NIC_NUM_IRQ; m++) begin
         if (candidate[m] &&
             (!best_found || prio_flat[2*m +: NIC_PRIO_W] < best_prio)) begin
            best_found = 1'b1; // see RQ10
            best_num = NIC_NUM_W'(m);
            best_prio = prio_flat[2*m +: NIC_PRIO_W];
         end
      end
   end

   // The offer is withdrawn in the cycle after it is taken.
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         OFFER_VALID <= 1'b0;
         OFFER_NUM <= '0;
         OFFER_PRIO <= '0;
      end else begin
         OFFER_VALID <= best_found & ~(|enter_mask); // see RQ2
         OFFER_NUM <= best_num;
         OFFER_PRIO <= best_prio;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   // Set and clear views of a vector return the same state.
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         vec_rdata <= NIC_RDATA_NONE;
         rd_prio_q <= 1'b0;
      end else begin
         rd_prio_q <= rd_prio;
         vec_rdata <= NIC_RDATA_NONE;
         if (rd_ok) begin
            unique case (sel)
               NIC_SEL_ENA_SET, NIC_SEL_ENA_CLR: begin
                  vec_rdata <= enable; // see RQ1, see RQ4
               end
               NIC_SEL_PEND_SET, NIC_SEL_PEND_CLR: begin
                  vec_rdata <= pending; // see RQ5, see RQ7
               end
               NIC_SEL_PRIO, NIC_SEL_NONE: begin
                  vec_rdata <= NIC_RDATA_NONE;
               end
               default: begin
                  vec_rdata <= NIC_RDATA_NONE;
               end
            endcase
         end
      end
   end

   assign REG_RDATA = rd_prio_q ? prio_rdata : vec_rdata;

endmodule : nic_ctrl

`default_nettype wire

// ### pkg/nic_pkg.sv
// Purpose: Shared constants and types of the nested interrupt controller.
// Assumes: Word-wide register port with byte offsets inside the block.
// Notes:   Offsets are relative to the start of the controller's region.

package nic_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NIC_NUM_IRQ = 32;
   localparam int NIC_NUM_W = 5;
   localparam int NIC_ADDR_W = 12;
   localparam int NIC_PRIO_W = 2;
   localparam int NIC_PRIO_WORDS = 8;
   localparam int NIC_PRIO_IDX_W = 3;
   localparam int NIC_FIELDS_PER_WORD = 4;
   localparam int NIC_FIELD_W = 8;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] NIC_OFF_ENA_SET = 12'h100;
   localparam logic [11:0] NIC_OFF_ENA_CLR = 12'h180;
   localparam logic [11:0] NIC_OFF_PEND_SET = 12'h200;
   localparam logic [11:0] NIC_OFF_PEND_CLR = 12'h280;
   localparam logic [11:0] NIC_OFF_PRIO_FIRST = 12'h400;
   localparam logic [11:0] NIC_OFF_PRIO_LAST = 12'h41c;

   // ---------------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------------
   localparam int NIC_PRIO_MSB = 7;
   localparam int NIC_PRIO_LSB = 6;
   localparam logic [31:0] NIC_RST_ENABLE = 32'h0000_0000;
   localparam logic [31:0] NIC_RST_PENDING = 32'h0000_0000;
   localparam logic [31:0] NIC_RST_ACTIVE = 32'h0000_0000;
   localparam logic [7:0] NIC_RST_PRIO = 8'h00;
   localparam logic [31:0] NIC_RDATA_NONE = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Register select
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      NIC_SEL_NONE = 3'b000,
      NIC_SEL_ENA_SET = 3'b001,
      NIC_SEL_ENA_CLR = 3'b010,
      NIC_SEL_PEND_SET = 3'b011,
      NIC_SEL_PEND_CLR = 3'b100,
      NIC_SEL_PRIO = 3'b101
   } nic_sel_t;

endpackage : nic_pkg

// ### rtl/nic_prio_mem.sv
// Purpose: Storage of the eight priority words, two bits per interrupt.
// Assumes: Only whole-word writes reach this module.
// Notes:   Read data come out of a register one cycle after the strobe.

`timescale 1ns/1ns
`default_nettype none

module nic_prio_mem
   import nic_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [NIC_PRIO_IDX_W-1:0] idx,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata,
   output logic [2*NIC_NUM_IRQ-1:0] prio_flat
);

   // ---------------------------------------------------------------
   // Storage: only the two top bits of each byte field exist.
   // ---------------------------------------------------------------
   logic [NIC_PRIO_W-1:0] field [NIC_NUM_IRQ];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int m = 0; m < NIC_NUM_IRQ; m++) begin
            field[m] <= NIC_RST_PRIO[NIC_PRIO_MSB:NIC_PRIO_LSB];
         end
      end else if (wr_en) begin
         for (int b = 0; b < NIC_FIELDS_PER_WORD; b++) begin
            // Low six bits of each lane are dropped.
            field[{idx, 2'(b)}] <=
               wdata[b*NIC_FIELD_W+NIC_PRIO_LSB +: NIC_PRIO_W];
         end
      end
   end

   // ---------------------------------------------------------------
   // Registered read: lane b of word idx holds interrupt 4*idx+b.
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= NIC_RDATA_NONE;
      end else if (rd_en) begin
         rdata <= NIC_RDATA_NONE;
         for (int b = 0; b < NIC_FIELDS_PER_WORD; b++) begin
            rdata[b*NIC_FIELD_W+NIC_PRIO_LSB +: NIC_PRIO_W] <=
               field[{idx, 2'(b)}];
         end
      end
   end

   always_comb begin
      for (int m = 0; m < NIC_NUM_IRQ; m++) begin
         prio_flat[2*m +: NIC_PRIO_W] = field[m];
      end
   end

endmodule : nic_prio_mem

`default_nettype wire

// ### test/nic_ctrl_properties.sv
// Purpose: Concurrent checks on the ports of the interrupt controller.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Bound to every instance of nic_ctrl.
`timescale 1ns/1ns
`default_nettype none
module nic_ctrl_chk
   import nic_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic REG_WORD,
   input wire logic [NIC_ADDR_W-1:0] REG_ADDR,
   input wire logic [31:0] REG_RDATA,
   input wire logic OFFER_VALID,
   input wire logic [NIC_NUM_W-1:0] OFFER_NUM,
   input wire logic CORE_ENTER,
   input wire logic [NIC_NUM_W-1:0] CORE_ENTER_NUM,
   input wire logic CORE_RETURN,
   input wire logic [NIC_NUM_W-1:0] CORE_RETURN_NUM,
   input wire logic [NIC_NUM_IRQ-1:0] ACTIVE_STATE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   property p_refused;
      !REG_RD || !REG_WORD |=> REG_RDATA == NIC_RDATA_NONE;
   endproperty
   a_refused: assert property (p_refused)
      else $error("stray read data");
   property p_prio_zero;
      REG_RD && REG_WORD && REG_ADDR >= NIC_OFF_PRIO_FIRST &&
         REG_ADDR <= NIC_OFF_PRIO_LAST |=> (REG_RDATA & 32'h3f3f_3f3f) == 32'h0;
   endproperty
   a_prio_zero: assert property (p_prio_zero)
      else $error("low bits set");
   property p_ena_mirror;
      REG_RD && REG_WORD && REG_ADDR == NIC_OFF_ENA_SET ##1 REG_RD &&
         REG_WORD && REG_ADDR == NIC_OFF_ENA_CLR && !REG_WR
         |=> REG_RDATA == $past(REG_RDATA);
   endproperty
   a_ena_mirror: assert property (p_ena_mirror)
      else $error("enable views differ");
   property p_enter_active;
      CORE_ENTER && OFFER_VALID && OFFER_NUM == CORE_ENTER_NUM && !REG_WR &&
         !$past(REG_WR) |=> ACTIVE_STATE[$past(CORE_ENTER_NUM)];
   endproperty
   a_enter_active: assert property (p_enter_active)
      else $error("not active");
   property p_offer_drop;
      CORE_ENTER && OFFER_VALID && OFFER_NUM == CORE_ENTER_NUM |=> ##1
         !(OFFER_VALID && OFFER_NUM == $past(CORE_ENTER_NUM, 2));
   endproperty
   a_offer_drop: assert property (p_offer_drop)
      else $error("active offered");
   property p_return_clears;
      CORE_RETURN && ACTIVE_STATE[CORE_RETURN_NUM] |=>
         !ACTIVE_STATE[$past(CORE_RETURN_NUM)];
   endproperty
   a_return_clears: assert property (p_return_clears)
      else $error("still active");
   property p_set_by_enter;
      (ACTIVE_STATE & ~$past(ACTIVE_STATE)) != 32'h0 |-> $past(CORE_ENTER);
   endproperty
   a_set_by_enter: assert property (p_set_by_enter)
      else $error("active without entry");
   property p_clr_by_return;
      ($past(ACTIVE_STATE) & ~ACTIVE_STATE) != 32'h0 |-> $past(CORE_RETURN);
   endproperty
   a_clr_by_return: assert property (p_clr_by_return)
      else $error("lost active");
   property p_wr_keeps_active;
      REG_WR && !CORE_ENTER && !CORE_RETURN |=> $stable(ACTIVE_STATE);
   endproperty
   a_wr_keeps_active: assert property (p_wr_keeps_active)
      else $error("write hit active");
endmodule : nic_ctrl_chk
bind nic_ctrl nic_ctrl_chk u_chk (.CLOCK(CLOCK), .RESET(RESET),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WORD(REG_WORD), .REG_ADDR(REG_ADDR),
   .REG_RDATA(REG_RDATA), .OFFER_VALID(OFFER_VALID), .OFFER_NUM(OFFER_NUM),
   .CORE_ENTER(CORE_ENTER), .CORE_ENTER_NUM(CORE_ENTER_NUM),
   .CORE_RETURN(CORE_RETURN), .CORE_RETURN_NUM(CORE_RETURN_NUM),
   .ACTIVE_STATE(ACTIVE_STATE));
`default_nettype wire

// ### test/nic_core_model.sv
// Purpose: Core side: takes the offered line, serves it, then returns.
// Assumes: One service at a time; take gates new entries only.
// Notes:   Drives on the falling edge; HOLD sets the service length.
`timescale 1ns/1ns
`default_nettype none
module nic_core_model
   import nic_pkg::*;
#(
   parameter int HOLD = 20
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic take,
   input wire logic offer_valid,
   input wire logic [NIC_NUM_W-1:0] offer_num,
   output logic enter,
   output logic [NIC_NUM_W-1:0] enter_num,
   output logic ret,
   output logic [NIC_NUM_W-1:0] ret_num
);
   int cnt;
   always @(negedge clk or posedge rst) begin
      if (rst) begin
         enter <= 1'b0;
         ret <= 1'b0;
         enter_num <= '0;
         ret_num <= '0;
         cnt <= 0;
      end else begin
         enter <= 1'b0;
         ret <= 1'b0;
         if (cnt != 0) begin
            cnt <= cnt - 1;
            ret <= (cnt == 1);
         end else if (take && offer_valid) begin
            enter <= 1'b1;
            enter_num <= offer_num;
            ret_num <= offer_num;
            cnt <= HOLD;
         end
      end
   end
endmodule : nic_core_model
`default_nettype wire

// ### test/tb_top.sv
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: Inputs change on the falling edge of CLOCK.
// Notes:   Line 6 is level-sensitive, all others are pulse lines.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module tb_top
   import nic_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] irq_req = '0;
   logic [31:0] irq_level = 32'h0000_0040;
   logic wr = 1'b0, rd = 1'b0, word = 1'b1, take = 1'b0;
   logic [11:0] addr = '0;
   logic [31:0] wdata = '0, rdata, active;
   logic ov, ent, ret;
   logic [4:0] onum, ent_num, ret_num;
   logic [1:0] oprio;
   int miscompares = 0;
   int tests_run = 0;
   always #20 clk = ~clk;
   nic_ctrl dut (.CLOCK(clk), .RESET(rst), .IRQ_REQ(irq_req),
      .IRQ_LEVEL(irq_level), .REG_WR(wr), .REG_RD(rd), .REG_WORD(word),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .OFFER_VALID(ov),
      .OFFER_NUM(onum), .OFFER_PRIO(oprio), .CORE_ENTER(ent),
      .CORE_ENTER_NUM(ent_num), .CORE_RETURN(ret), .CORE_RETURN_NUM(ret_num),
      .ACTIVE_STATE(active));
   nic_core_model core (.clk(clk), .rst(rst), .take(take), .offer_valid(ov),
      .offer_num(onum), .enter(ent), .enter_num(ent_num), .ret(ret),
      .ret_num(ret_num));
   task automatic wrr(input logic [11:0] a, input logic [31:0] d);
      @(negedge clk);
      wr = 1'b1; addr = a; wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask : wrr
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      @(negedge clk);
      rd = 1'b1; addr = a;
      @(negedge clk);
      rd = 1'b0;
      `CHK(rdata, e)
   endtask : rdc
   task automatic pulse(input int n);
      @(negedge clk);
      irq_req[n] = 1'b1;
      @(negedge clk);
      irq_req[n] = 1'b0;
   endtask : pulse
   task automatic wait_act(input int n, input logic v);
      for (int i = 0; i < 100 && active[n] !== v; i++) @(negedge clk);
      `CHK(active[n], v)
   endtask : wait_act
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic t_regs();
      rdc(NIC_OFF_ENA_SET, 32'h0);
      rdc(NIC_OFF_PRIO_LAST, 32'h0);
      wrr(NIC_OFF_ENA_SET, 32'ha5a5_0001);
      wrr(NIC_OFF_ENA_SET, 32'h0);
      wrr(NIC_OFF_ENA_CLR, 32'h0000_0001);
      @(negedge clk);
      rd = 1'b1; addr = NIC_OFF_ENA_SET;
      @(negedge clk);
      addr = NIC_OFF_ENA_CLR;
      @(negedge clk);
      rd = 1'b0;
      `CHK(rdata, 32'ha5a5_0000)
      wrr(NIC_OFF_ENA_CLR, 32'hffff_ffff);
      wrr(NIC_OFF_PEND_SET, 32'h8000_0010);
      wrr(NIC_OFF_PEND_SET, 32'h8000_0010);
      rdc(NIC_OFF_PEND_CLR, 32'h8000_0010);
      wrr(NIC_OFF_PEND_CLR, 32'h0000_0010);
      rdc(NIC_OFF_PEND_SET, 32'h8000_0000);
      wrr(NIC_OFF_PEND_CLR, 32'hffff_ffff);
      wrr(NIC_OFF_PRIO_FIRST + 12'hc, 32'hc0c0_41ff);
      rdc(NIC_OFF_PRIO_FIRST + 12'hc, 32'hc0c0_40c0);
      word = 1'b0;
      wrr(NIC_OFF_PRIO_FIRST + 12'hc, 32'h0);
      rdc(NIC_OFF_PRIO_FIRST + 12'hc, 32'h0);
      word = 1'b1;
      rdc(NIC_OFF_PRIO_FIRST + 12'hc, 32'hc0c0_40c0);
      rdc(12'h300, 32'h0);
   endtask : t_regs
   task automatic t_arb();
      wrr(NIC_OFF_PRIO_FIRST, 32'h0040_80c0);
      wrr(NIC_OFF_ENA_SET, 32'h7);
      wrr(NIC_OFF_PEND_SET, 32'hf);
      @(negedge clk);
      `CHK({ov, onum, oprio}, {1'b1, 5'h2, 2'h1})
      wrr(NIC_OFF_ENA_SET, 32'h8);
      @(negedge clk);
      `CHK({ov, onum, oprio}, {1'b1, 5'h3, 2'h0})
      wrr(NIC_OFF_PEND_CLR, 32'hf);
      wrr(NIC_OFF_ENA_CLR, 32'hf);
      @(negedge clk);
      `CHK(ov, 1'b0)
   endtask : t_arb
   task automatic t_pulse();
      wrr(NIC_OFF_ENA_SET, 32'h20);
      take = 1'b1;
      pulse(5);
      wait_act(5, 1'b1);
      take = 1'b0;
      rdc(NIC_OFF_PEND_SET, 32'h0);
      pulse(5);
      rdc(NIC_OFF_PEND_SET, 32'h20);
      wrr(NIC_OFF_PEND_CLR, 32'h20);
      `CHK(active[5], 1'b1)
      pulse(5);
      wait_act(5, 1'b0);
      rdc(NIC_OFF_PEND_SET, 32'h20);
      wrr(NIC_OFF_PEND_CLR, 32'h20);
      wrr(NIC_OFF_ENA_CLR, 32'h20);
   endtask : t_pulse
   task automatic t_level();
      wrr(NIC_OFF_ENA_SET, 32'h40);
      take = 1'b1;
      irq_req[6] = 1'b1;
      pulse(7);
      wait_act(6, 1'b1);
      take = 1'b0;
      rdc(NIC_OFF_PEND_SET, 32'h80);
      wait_act(6, 1'b0);
      rdc(NIC_OFF_PEND_SET, 32'hc0);
      `CHK({ov, onum}, {1'b1, 5'h6})
      irq_req[6] = 1'b0;
      wrr(NIC_OFF_PEND_CLR, 32'hc0);
      rdc(NIC_OFF_PEND_SET, 32'h0);
   endtask : t_level
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_regs();
      t_arb();
      t_pulse();
      t_level();
      stop_test();
   end
   initial begin
      #400000;
      miscompares++;
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
